/* File: tmc_pkg.sv */
// package: constants and types for the dual timer/counter block
package tmc_pkg;
	// -----------------------------------------------------------------
	// register map
	// -----------------------------------------------------------------
	localparam logic [7:0] TMC_ADDR_CTRL  = 8'h88;
	localparam logic [7:0] TMC_ADDR_MODE  = 8'h89;
	localparam logic [7:0] TMC_ADDR_LOW0  = 8'h8A;
	localparam logic [7:0] TMC_ADDR_LOW1  = 8'h8B;
	localparam logic [7:0] TMC_ADDR_HIGH0 = 8'h8C;
	localparam logic [7:0] TMC_ADDR_HIGH1 = 8'h8D;
	localparam logic [7:0] TMC_RST_CTRL   = 8'h00;
	localparam logic [7:0] TMC_RST_MODE   = 8'h00;
	localparam logic [7:0] TMC_RST_COUNT  = 8'h00;
	// control register bit positions
	localparam int TMC_CTRL_OVF1 = 7;
	localparam int TMC_CTRL_RUN1 = 6;
	localparam int TMC_CTRL_OVF0 = 5;
	localparam int TMC_CTRL_RUN0 = 4;
	// mode register bit positions
	localparam int TMC_MODE_GATE1 = 7;
	localparam int TMC_MODE_SEL1  = 6;
	localparam int TMC_MODE_M1HI  = 5;
	localparam int TMC_MODE_M1LO  = 4;
	localparam int TMC_MODE_GATE0 = 3;
	localparam int TMC_MODE_SEL0  = 2;
	localparam int TMC_MODE_M0HI  = 1;
	localparam int TMC_MODE_M0LO  = 0;
	// -----------------------------------------------------------------
	// timing
	// -----------------------------------------------------------------
	localparam int         TMC_PHASES_PER_CYCLE = 12;
	localparam logic [3:0] TMC_PHASE_LAST       = 4'(TMC_PHASES_PER_CYCLE - 1);
	localparam logic [3:0] TMC_SAMPLE_PHASE     = 4'h9; // state 5 phase 2
	localparam logic [3:0] TMC_UPDATE_PHASE     = 4'h4; // state 3 phase 1
	localparam int         TMC_PRESCALE_BITS    = 5;
	// -----------------------------------------------------------------
	// types
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		TMC_MODE_PRESCALED = 2'b00,
		TMC_MODE_CASCADED  = 2'b01,
		TMC_MODE_RELOAD    = 2'b10,
		TMC_MODE_SPLIT     = 2'b11
	} tmc_mode_t;
	// special function register access strobe bundle
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       bit_wr;
		logic [7:0] addr;
		logic [2:0] bit_idx;
		logic [7:0] wdata;
	} tmc_sfr_req_t;
endpackage : tmc_pkg

/* File: tmc_timer.sv */
// file: dual 16-bit timer/counter with mode and control registers
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - each unit is a high byte and a low byte of eight bits
// - timer operation counts one step per twelve-clock machine cycle
// - counter operation counts falling edges of the external count input
// - count input sampled once per machine cycle; count on high then low
// - detected edge updates the count at the update phase of next cycle
// - edge counting rate is at most one twenty-fourth of the clock
// - unit one gating bit 7 requires gate pin one high plus run bit
// - unit zero gating bit 3 requires gate pin zero high plus run bit
// - unit one select bit 6 chooses external counting, else timer
// - unit zero select bit 2 chooses external counting, else timer
// - mode 00: high byte counts, fed by five-bit low prescaler
// - mode 01: high and low cascade into one 16-bit counter
// - mode 10: low byte counts, reloaded from high byte on overflow
// - mode 11 on unit one stops it, holding the count
// - unit zero mode 11 splits into low counter and high timer
// - mode register resets to zero and is written only as a byte
// - control register resets to zero and allows single-bit writes
// - overflow sets flag; cleared when interrupt is vectored
// - run bit set does not clear count; software starts and stops
module tmc_timer (
	input  wire logic                  clk,
	input  wire logic                  nrst,
	input  wire tmc_pkg::tmc_sfr_req_t sfr_req,
	input  wire logic                  count_input_zero,
	input  wire logic                  count_input_one,
	input  wire logic                  gate_pin_zero,
	input  wire logic                  gate_pin_one,
	input  wire logic                  vector_ack0,
	input  wire logic                  vector_ack1,
	output logic [7:0]                 rdata,
	output logic                       ovf_flag0,
	output logic                       ovf_flag1
);
	import tmc_pkg::*;

	// -----------------------------------------------------------------
	// registers
	// -----------------------------------------------------------------
	logic [7:0] ctrl_r, mode_r, low0_r, high0_r, low1_r, high1_r, rdata_r;
	logic [7:0] ctrl_nxt, low0_nxt, high0_nxt, low1_nxt, high1_nxt;
	logic [3:0] phase_r;
	logic       samp0_r, samp1_r, edge0_r, edge1_r;

	// -----------------------------------------------------------------
	// machine cycle phase
	// -----------------------------------------------------------------
	// twelve clock phases per machine cycle
	always_ff @(posedge clk) begin
		if (!nrst) begin
			phase_r <= 4'h0;
		end else begin
			phase_r <= (phase_r == TMC_PHASE_LAST) ? 4'h0 : 4'(phase_r + 4'h1);
		end
	end

	wire tick_smp = (phase_r == TMC_SAMPLE_PHASE);
	wire tick_upd = (phase_r == TMC_UPDATE_PHASE);

	// -----------------------------------------------------------------
	// external input sampling
	// -----------------------------------------------------------------
	// one sample per cycle; edge held until next cycle's update phase
	always_ff @(posedge clk) begin
		if (!nrst) begin
			samp0_r <= 1'b0;
			samp1_r <= 1'b0;
			edge0_r <= 1'b0;
			edge1_r <= 1'b0;
		end else begin
			if (tick_smp) begin
				samp0_r <= count_input_zero;
				samp1_r <= count_input_one;
				edge0_r <= samp0_r & ~count_input_zero;
				edge1_r <= samp1_r & ~count_input_one;
			end
		end
	end

	// -----------------------------------------------------------------
	// decode of mode and control
	// -----------------------------------------------------------------
	wire tmc_mode_t mode0 = tmc_mode_t'({mode_r[TMC_MODE_M0HI], mode_r[TMC_MODE_M0LO]});
	wire tmc_mode_t mode1 = tmc_mode_t'({mode_r[TMC_MODE_M1HI], mode_r[TMC_MODE_M1LO]});
	wire run0 = ctrl_r[TMC_CTRL_RUN0] & (~mode_r[TMC_MODE_GATE0] | gate_pin_zero);
	wire run1 = ctrl_r[TMC_CTRL_RUN1] & (~mode_r[TMC_MODE_GATE1] | gate_pin_one);
	// counting step: timer ticks or detected edge, both at update phase
	wire src0 = mode_r[TMC_MODE_SEL0] ? edge0_r : 1'b1;
	wire src1 = mode_r[TMC_MODE_SEL1] ? edge1_r : 1'b1;
	wire inc0 = tick_upd & run0 & src0;
	wire inc1 = tick_upd & run1 & src1 & (mode1 != TMC_MODE_SPLIT);
	// split-mode high byte: timer only, gated by unit one run bit
	wire inc0h = tick_upd & ctrl_r[TMC_CTRL_RUN1] & (mode0 == TMC_MODE_SPLIT);

	// -----------------------------------------------------------------
	// bus write decode
	// -----------------------------------------------------------------
	wire wr_byte  = sfr_req.wr;
	wire wr_ctrl  = wr_byte & (sfr_req.addr == TMC_ADDR_CTRL);
	wire wr_cbit  = sfr_req.bit_wr & (sfr_req.addr == TMC_ADDR_CTRL);
	wire wr_mode  = wr_byte & (sfr_req.addr == TMC_ADDR_MODE);
	wire wr_low0  = wr_byte & (sfr_req.addr == TMC_ADDR_LOW0);
	wire wr_low1  = wr_byte & (sfr_req.addr == TMC_ADDR_LOW1);
	wire wr_high0 = wr_byte & (sfr_req.addr == TMC_ADDR_HIGH0);
	wire wr_high1 = wr_byte & (sfr_req.addr == TMC_ADDR_HIGH1);

	// -----------------------------------------------------------------
	// count engine per unit; returns {ovf, high, low}
	// -----------------------------------------------------------------
	function automatic logic [16:0] step(input tmc_mode_t m, input logic en,
		input logic [7:0] hi, input logic [7:0] lo);
		logic [16:0] r;
		logic [5:0]  p;
		logic [8:0]  l;
		logic [8:0]  h;
		logic [16:0] w;
		r = {1'b0, hi, lo};
		p = {1'b0, lo[4:0]} + 6'h01;
		l = {1'b0, lo} + 9'h001;
		h = {1'b0, hi} + 9'h001;
		w = {1'b0, hi, lo} + 17'h0_0001;
		if (en) begin
			unique case (m)
				TMC_MODE_PRESCALED: begin
					if (p[5]) begin
						r = {h[8], h[7:0], lo[7:5], 5'b0_0000};
					end else begin
						r = {1'b0, hi, lo[7:5], p[4:0]};
					end
				end
				TMC_MODE_CASCADED: r = w;
				TMC_MODE_RELOAD:   r = {l[8], hi, l[8] ? hi : l[7:0]};
				TMC_MODE_SPLIT:    r = {l[8], hi, l[7:0]};
			endcase
		end
		return r;
	endfunction

	wire [16:0] s0 = step(mode0, inc0, high0_r, low0_r);
	wire [16:0] s1 = step(mode1, inc1, high1_r, low1_r);
	wire [8:0]  h0s = {1'b0, high0_r} + 9'h001;
	wire        ovf_h0 = inc0h & h0s[8];
	// unit one flag belongs to split high byte while unit zero in mode 3
	wire set0 = s0[16];
	wire set1 = (mode0 == TMC_MODE_SPLIT) ? ovf_h0 : s1[16];

	// next values; bus write wins over counting, giving a fresh start
	always_comb begin
		low0_nxt  = wr_low0  ? sfr_req.wdata : s0[7:0];
		low1_nxt  = wr_low1  ? sfr_req.wdata : s1[7:0];
		high1_nxt = wr_high1 ? sfr_req.wdata : s1[15:8];
		if (wr_high0) begin
			high0_nxt = sfr_req.wdata;
		end else if (mode0 == TMC_MODE_SPLIT) begin
			high0_nxt = inc0h ? h0s[7:0] : high0_r;
		end else begin
			high0_nxt = s0[15:8];
		end
		ctrl_nxt = ctrl_r;
		if (wr_ctrl) begin
			ctrl_nxt = sfr_req.wdata;
		end else if (wr_cbit) begin
			ctrl_nxt[sfr_req.bit_idx] = sfr_req.wdata[0];
		end
		// vector clears; a same-cycle overflow set wins
		if (vector_ack0) ctrl_nxt[TMC_CTRL_OVF0] = 1'b0;
		if (vector_ack1) ctrl_nxt[TMC_CTRL_OVF1] = 1'b0;
		if (set0) ctrl_nxt[TMC_CTRL_OVF0] = 1'b1;
		if (set1) ctrl_nxt[TMC_CTRL_OVF1] = 1'b1;
	end

	// read mux, registered
	wire [7:0] rd_mux =
		(sfr_req.addr == TMC_ADDR_CTRL)  ? ctrl_r  :
		(sfr_req.addr == TMC_ADDR_MODE)  ? mode_r  :
		(sfr_req.addr == TMC_ADDR_LOW0)  ? low0_r  :
		(sfr_req.addr == TMC_ADDR_LOW1)  ? low1_r  :
		(sfr_req.addr == TMC_ADDR_HIGH0) ? high0_r :
		(sfr_req.addr == TMC_ADDR_HIGH1) ? high1_r : 8'h00;

	// register update; run bit never touches count bytes
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ctrl_r  <= TMC_RST_CTRL;
			mode_r  <= TMC_RST_MODE;
			low0_r  <= TMC_RST_COUNT;
			high0_r <= TMC_RST_COUNT;
			low1_r  <= TMC_RST_COUNT;
			high1_r <= TMC_RST_COUNT;
			rdata_r <= 8'h00;
		end else begin
			ctrl_r  <= ctrl_nxt;
			mode_r  <= wr_mode ? sfr_req.wdata : mode_r;
			low0_r  <= low0_nxt;
			high0_r <= high0_nxt;
			low1_r  <= low1_nxt;
			high1_r <= high1_nxt;
			rdata_r <= sfr_req.rd ? rd_mux : rdata_r;
		end
	end

	assign rdata     = rdata_r;
	assign ovf_flag0 = ctrl_r[TMC_CTRL_OVF0];
	assign ovf_flag1 = ctrl_r[TMC_CTRL_OVF1];

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	property p_phase_wrap;
		@(posedge clk) disable iff (!nrst)
		(phase_r == TMC_PHASE_LAST) |=> (phase_r == 4'h0);
	endproperty
	a_phase_wrap: assert property (p_phase_wrap) else $error("phase did not wrap");

	property p_timer_step;
		@(posedge clk) disable iff (!nrst)
		(tick_upd && run0 && !mode_r[TMC_MODE_SEL0] && mode0 == TMC_MODE_CASCADED
			&& !wr_low0 && !wr_high0) |=> ({high0_r, low0_r} == $past({high0_r, low0_r}) + 16'h0001);
	endproperty
	a_timer_step: assert property (p_timer_step) else $error("timer step wrong");

	property p_edge_detect;
		@(posedge clk) disable iff (!nrst)
		(tick_smp && samp0_r && !count_input_zero) |=> edge0_r;
	endproperty
	a_edge_detect: assert property (p_edge_detect) else $error("edge missed");

	property p_gate0;
		@(posedge clk) disable iff (!nrst)
		(mode_r[TMC_MODE_GATE0] && !gate_pin_zero) |-> !inc0;
	endproperty
	a_gate0: assert property (p_gate0) else $error("gated unit zero counted");

	property p_gate1;
		@(posedge clk) disable iff (!nrst)
		(!ctrl_r[TMC_CTRL_RUN1] || (mode_r[TMC_MODE_GATE1] && !gate_pin_one)) |-> !inc1;
	endproperty
	a_gate1: assert property (p_gate1) else $error("gated unit one counted");

	property p_stop1;
		@(posedge clk) disable iff (!nrst)
		(mode1 == TMC_MODE_SPLIT && !wr_low1 && !wr_high1) |=> ({high1_r, low1_r} == $past({high1_r, low1_r}));
	endproperty
	a_stop1: assert property (p_stop1) else $error("stopped unit one moved");

	property p_reload;
		@(posedge clk) disable iff (!nrst)
		(inc0 && mode0 == TMC_MODE_RELOAD && low0_r == 8'hFF && !wr_low0 && !wr_high0)
			|=> (low0_r == high0_r) && ovf_flag0;
	endproperty
	a_reload: assert property (p_reload) else $error("reload failed");

	property p_mode_hold;
		@(posedge clk) disable iff (!nrst)
		!wr_mode |=> $stable(mode_r);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed unwritten");

	property p_split_high;
		@(posedge clk) disable iff (!nrst)
		(inc0h && !wr_high0) |=> (high0_r == $past(high0_r) + 8'h01);
	endproperty
	a_split_high: assert property (p_split_high) else $error("split high step wrong");

	property p_prescale_step;
		@(posedge clk) disable iff (!nrst)
		(inc0 && mode0 == TMC_MODE_PRESCALED && !wr_low0 && !wr_high0)
			|=> (low0_r[4:0] == 5'($past(low0_r[4:0]) + 5'h01));
	endproperty
	a_prescale_step: assert property (p_prescale_step) else $error("prescale step");

	property p_count_edge;
		@(posedge clk) disable iff (!nrst)
		(tick_upd && run0 && mode_r[TMC_MODE_SEL0] && edge0_r && mode0 == TMC_MODE_CASCADED
			&& !wr_low0 && !wr_high0) |=> (low0_r == $past(low0_r) + 8'h01);
	endproperty
	a_count_edge: assert property (p_count_edge) else $error("edge not counted");

	property p_no_edge;
		@(posedge clk) disable iff (!nrst)
		(tick_upd && mode_r[TMC_MODE_SEL0] && !edge0_r && !wr_low0) |=> $stable(low0_r);
	endproperty
	a_no_edge: assert property (p_no_edge) else $error("count without edge");

	// overflow flag: a set beats a same-cycle clear, then stays until cleared
	property p_ovf_set;
		@(posedge clk) disable iff (!nrst)
		set0 |=> ovf_flag0;
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

	property p_ovf_sticky;
		@(posedge clk) disable iff (!nrst)
		(ovf_flag0 && !vector_ack0 && !wr_ctrl && !wr_cbit) |=> ovf_flag0;
	endproperty
	a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag dropped");

	c_reload:  cover property (@(posedge clk) disable iff (!nrst) inc0 && mode0 == TMC_MODE_RELOAD && s0[16]);
	c_split:   cover property (@(posedge clk) disable iff (!nrst) ovf_h0);
	c_counter: cover property (@(posedge clk) disable iff (!nrst) inc1 && mode_r[TMC_MODE_SEL1]);
	c_gated:   cover property (@(posedge clk) disable iff (!nrst) edge0_r && !gate_pin_zero);
	c_ack:     cover property (@(posedge clk) disable iff (!nrst) vector_ack0 && ovf_flag0);
endmodule : tmc_timer
`default_nettype wire

/* File: tmc_pin_model.sv */
// partner model: external count input and gating pins of the timer block
`timescale 1ns/100ps
`default_nettype none
module tmc_pin_model (
	input  wire logic       clk,
	input  wire logic       go,
	input  wire logic       unit,
	input  wire logic       slow,
	input  wire logic [3:0] pulses,
	input  wire logic       gate0,
	input  wire logic       gate1,
	output logic            count_input_zero,
	output logic            count_input_one,
	output logic            gate_pin_zero,
	output logic            gate_pin_one,
	output logic            busy
);
	logic [3:0] left_r = 4'h0;
	logic [4:0] tick_r = 5'h00;
	logic       lvl_r  = 1'b1;
	logic       sel_r  = 1'b0;
	wire  [4:0] last   = slow ? 5'h17 : 5'h0B;
	// gating pins follow the requested levels
	assign gate_pin_zero = gate0;
	assign gate_pin_one  = gate1;
	// unselected input rests high on its pull-up
	assign count_input_zero = sel_r ? 1'b1 : lvl_r;
	assign count_input_one  = sel_r ? lvl_r : 1'b1;
	assign busy = (left_r != 4'h0);
	// each level held 12 or 24 clocks, never shorter
	always @(posedge clk) begin
		if (go && !busy) begin
			left_r <= pulses;
			sel_r  <= unit;
			tick_r <= 5'h00;
		end else if (busy) begin
			tick_r <= (tick_r == last) ? 5'h00 : tick_r + 5'h01;
			if (tick_r == last) begin
				lvl_r <= ~lvl_r;
				if (!lvl_r)
					left_r <= left_r - 4'h1;
			end
		end
	end
endmodule // tmc_pin_model
`default_nettype wire

/* File: tmc_timer_test.sv */
// testbench: dual timer/counter driven through its register strobes and pins
`timescale 1ns/100ps
`default_nettype none
module tmc_timer_test;
	import tmc_pkg::*;
	logic         clk = 1'b0;
	logic         nrst = 1'b0;
	tmc_sfr_req_t req = '0;
	logic         ack0 = 1'b0;
	logic         ack1 = 1'b0;
	logic         go = 1'b0;
	logic         unit = 1'b0;
	logic         slow = 1'b0;
	logic [3:0]   pulses = 4'h0;
	logic         g0 = 1'b0;
	logic         g1 = 1'b0;
	wire logic    ci0, ci1, gp0, gp1, busy, of0, of1;
	wire logic [7:0] rdata;
	int           fail_count = 0;
	int           n_tests = 0;
	tmc_timer tmc_timer_inst (.clk(clk), .nrst(nrst), .sfr_req(req),
		.count_input_zero(ci0), .count_input_one(ci1), .gate_pin_zero(gp0),
		.gate_pin_one(gp1), .vector_ack0(ack0), .vector_ack1(ack1), .rdata(rdata),
		.ovf_flag0(of0), .ovf_flag1(of1));
	tmc_pin_model tmc_pin_model_inst (.clk(clk), .go(go), .unit(unit), .slow(slow),
		.pulses(pulses), .gate0(g0), .gate1(g1), .count_input_zero(ci0),
		.count_input_one(ci1), .gate_pin_zero(gp0), .gate_pin_one(gp1), .busy(busy));
	// 25 ns clock
	initial forever #12.5 clk = ~clk;
	// ---------------------------------------------------------------
	// shared bus and compare tasks
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk1(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b = 1'b0,
		input logic [2:0] i = 3'h0);
		@(posedge clk);
		req.wr <= ~b;
		req.bit_wr <= b;
		req.addr <= a;
		req.bit_idx <= i;
		req.wdata <= d;
		@(posedge clk);
		req.wr <= 1'b0;
		req.bit_wr <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm,
		input logic [7:0] m = 8'hFF);
		@(posedge clk);
		req.rd <= 1'b1;
		req.addr <= a;
		@(posedge clk);
		req.rd <= 1'b0;
		@(posedge clk);
		#1 chk(nm, e, rdata & m);
	endtask
	// run bit b set for exactly n clocks of counting
	task automatic run(input logic [2:0] b, input int n);
		wr(TMC_ADDR_CTRL, 8'h01, 1'b1, b);
		repeat (n - 2) @(posedge clk);
		wr(TMC_ADDR_CTRL, 8'h00, 1'b1, b);
	endtask
	task automatic ack(input logic u);
		@(posedge clk);
		if (u) ack1 <= 1'b1; else ack0 <= 1'b1;
		@(posedge clk);
		ack0 <= 1'b0;
		ack1 <= 1'b0;
		@(posedge clk);
	endtask
	task automatic pins(input logic u, input logic [3:0] n, input logic s);
		@(posedge clk);
		go <= 1'b1;
		unit <= u;
		pulses <= n;
		slow <= s;
		@(posedge clk);
		go <= 1'b0;
		// busy rises with this edge's update; look at it half a clock later
		@(negedge clk);
		for (int k = 0; k < 2000 && busy; k++) @(negedge clk);
		chk1("pin model finished", 1'b0, busy);
		repeat (30) @(posedge clk);
	endtask
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_regs();
		rc(TMC_ADDR_CTRL, 8'h00, "ctrl reset");
		rc(TMC_ADDR_MODE, 8'h00, "mode reset");
		rc(TMC_ADDR_HIGH1, 8'h00, "high1 reset");
		rc(8'hFF, 8'h00, "unmapped");
		wr(TMC_ADDR_MODE, 8'hA5);
		wr(TMC_ADDR_MODE, 8'h00, 1'b1, 3'h0);
		rc(TMC_ADDR_MODE, 8'hA5, "mode no bit write");
		wr(TMC_ADDR_CTRL, 8'h01, 1'b1, 3'h6);
		rc(TMC_ADDR_CTRL, 8'h40, "ctrl bit write");
		wr(TMC_ADDR_CTRL, 8'h00);
	endtask
	task automatic t_timer();
		wr(TMC_ADDR_MODE, 8'h01);
		wr(TMC_ADDR_LOW0, 8'hFE);
		wr(TMC_ADDR_HIGH0, 8'hFF);
		run(3'h4, 36);
		rc(TMC_ADDR_LOW0, 8'h01, "mode1 low0");
		rc(TMC_ADDR_HIGH0, 8'h00, "mode1 high0");
		chk1("ovf0 set", 1'b1, of0);
		ack(1'b0);
		chk1("ovf0 cleared", 1'b0, of0);
		run(3'h4, 12);
		rc(TMC_ADDR_LOW0, 8'h02, "restart keeps count");
		wr(TMC_ADDR_MODE, 8'h00);
		wr(TMC_ADDR_LOW0, 8'h1F);
		wr(TMC_ADDR_HIGH0, 8'h05);
		run(3'h4, 12);
		rc(TMC_ADDR_LOW0, 8'h00, "mode0 prescaler", 8'h1F);
		rc(TMC_ADDR_HIGH0, 8'h06, "mode0 high0");
		wr(TMC_ADDR_MODE, 8'h20);
		wr(TMC_ADDR_HIGH1, 8'hA0);
		wr(TMC_ADDR_LOW1, 8'hFF);
		run(3'h6, 12);
		rc(TMC_ADDR_LOW1, 8'hA0, "mode2 reload");
		rc(TMC_ADDR_HIGH1, 8'hA0, "mode2 high1 kept");
		chk1("ovf1 set", 1'b1, of1);
		ack(1'b1);
	endtask
	task automatic t_split();
		wr(TMC_ADDR_MODE, 8'h33);
		wr(TMC_ADDR_LOW0, 8'h00);
		wr(TMC_ADDR_HIGH0, 8'h00);
		wr(TMC_ADDR_LOW1, 8'h55);
		wr(TMC_ADDR_CTRL, 8'h50);
		repeat (22) @(posedge clk);
		wr(TMC_ADDR_CTRL, 8'h00);
		rc(TMC_ADDR_LOW0, 8'h02, "split low0");
		rc(TMC_ADDR_HIGH0, 8'h02, "split high0");
		rc(TMC_ADDR_LOW1, 8'h55, "unit1 stopped");
	endtask
	task automatic t_count();
		wr(TMC_ADDR_MODE, 8'h0D);
		wr(TMC_ADDR_LOW0, 8'h00);
		wr(TMC_ADDR_HIGH0, 8'h00);
		wr(TMC_ADDR_CTRL, 8'h01, 1'b1, 3'h4);
		pins(1'b0, 4'h3, 1'b0);
		rc(TMC_ADDR_LOW0, 8'h00, "gated off low0");
		@(posedge clk);
		g0 <= 1'b1;
		pins(1'b0, 4'h3, 1'b1);
		rc(TMC_ADDR_LOW0, 8'h03, "edges low0");
		wr(TMC_ADDR_CTRL, 8'h00);
		wr(TMC_ADDR_MODE, 8'hD0);
		wr(TMC_ADDR_LOW1, 8'h00);
		g1 <= 1'b1;
		wr(TMC_ADDR_CTRL, 8'h01, 1'b1, 3'h6);
		pins(1'b1, 4'h2, 1'b0);
		rc(TMC_ADDR_LOW1, 8'h02, "edges low1");
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// main sequence after 16 clocks of reset
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_timer();
		t_split();
		t_count();
		complete_run();
	end
	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		complete_run();
	end
endmodule // tmc_timer_test
`default_nettype wire
